//--- rtl/wdt_top.sv
// watchdog timer unit: down counter, restart key, two timeout modes,
// reset pulse generator, reset-cause record, irq status and mask
// assumes a classic wishbone master on clk_i and a synchronous
// active-high power-on reset on rst_i; the counter time base is clk_i
//
// The Wishbone register port was chosen for this implementation.
`include "wdt_consts.svh"

module wdt_top #(
    // restart key; value arbitrary
    parameter logic [31:0] RESTART_KEY = 32'h5A5AC3C3
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // system side
    output logic             wdt_rst_o,
    output logic             irq_o
);
    // register state
    logic [31:0] count_r;      // live down counter
    logic [31:0] reload_r;     // value copied on restart
    logic [5:0]  ctrl_r;       // control fields
    logic        flag_r;       // timeout status flag
    logic [1:0]  cause_r;      // reset-cause bits
    logic [15:0] plen_r;       // reset pulse length
    logic [1:0]  irq_st_r;     // sticky event bits
    logic [1:0]  irq_st_nxt;   // their next value
    logic [1:0]  irq_msk_r;    // event mask
    logic [1:0]  irq_msk_nxt;  // mask after this edge
    logic [15:0] pulse_r;      // remaining pulse cycles

    // bus decode
    logic        req;          // access accepted this cycle
    logic        wr;           // accepted write
    logic        rd;           // accepted read
    logic [31:0] wmask;        // byte-lane write mask
    logic        hit_reload;
    logic        hit_restart;
    logic        hit_ctrl;
    logic        hit_fclr;
    logic        hit_cause;
    logic        hit_plen;
    logic        hit_irqst;
    logic        hit_irqmsk;

    // timer events
    logic        tick;         // prescaled count pulse
    logic        key_ok;       // valid restart write
    logic        zero_evt;     // counter reaches zero now
    logic        mode1;        // two-stage mode selected
    logic        trig;         // start a watchdog reset
    logic        irq_evt;      // watchdog interrupt event
    logic        wd_clr;       // soft reset of timer registers

    // a request is served in the cycle after it appears
    assign req = cyc_i && stb_i && !ack_o;
    assign wr  = req && we_i;
    assign rd  = req && !we_i;

    // word indices, sized to the decoded address bits so that every
    // compare and case item is six bits wide like adr_i[7:2]
    localparam logic [5:0] IDX_COUNT   = 6'(`WDT_OFF_COUNT   >> 2);
    localparam logic [5:0] IDX_RELOAD  = 6'(`WDT_OFF_RELOAD  >> 2);
    localparam logic [5:0] IDX_RESTART = 6'(`WDT_OFF_RESTART >> 2);
    localparam logic [5:0] IDX_CTRL    = 6'(`WDT_OFF_CTRL    >> 2);
    localparam logic [5:0] IDX_FLAG    = 6'(`WDT_OFF_FLAG    >> 2);
    localparam logic [5:0] IDX_FCLR    = 6'(`WDT_OFF_FCLR    >> 2);
    localparam logic [5:0] IDX_CAUSE   = 6'(`WDT_OFF_CAUSE   >> 2);
    localparam logic [5:0] IDX_PLEN    = 6'(`WDT_OFF_PLEN    >> 2);
    localparam logic [5:0] IDX_IRQST   = 6'(`WDT_OFF_IRQST   >> 2);
    localparam logic [5:0] IDX_IRQMSK  = 6'(`WDT_OFF_IRQMSK  >> 2);

    // word decode; offsets are byte addresses on word bounds
    // the two low address bits are ignored, so a byte address inside
    // a word still reaches that word
    assign hit_reload  = adr_i[7:2] == IDX_RELOAD;
    assign hit_restart = adr_i[7:2] == IDX_RESTART;
    assign hit_ctrl    = adr_i[7:2] == IDX_CTRL;
    assign hit_fclr    = adr_i[7:2] == IDX_FCLR;
    assign hit_cause   = adr_i[7:2] == IDX_CAUSE;
    assign hit_plen    = adr_i[7:2] == IDX_PLEN;
    assign hit_irqst   = adr_i[7:2] == IDX_IRQST;
    assign hit_irqmsk  = adr_i[7:2] == IDX_IRQMSK;

    // byte lanes turn into a bit mask for partial writes
    assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}},
                    {8{sel_i[1]}}, {8{sel_i[0]}}};

    // full-word key only
    // the key must arrive whole; a partial write can never match
    assign key_ok = wr && hit_restart && sel_i == 4'hF
                    && dat_i == RESTART_KEY;

    assign mode1 = ctrl_r[`WDT_CTRL_MODE];

    // prescaler runs only while counting is enabled
    wdt_prescaler u_presc (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .en_i   (ctrl_r[`WDT_CTRL_EN]),
        .clr_i  (key_ok || wd_clr),
        .div_i  (wdt_pkg::wdt_div_t'(
                  ctrl_r[`WDT_CTRL_PS_HI:`WDT_CTRL_PS_LO])),
        .tick_o (tick)
    );

    // zero is reached when a tick takes the counter from one
    // a counter already at zero stays quiet, so no repeat events
    assign zero_evt = ctrl_r[`WDT_CTRL_EN] && tick
                      && count_r == 32'h1 && !key_ok;

    // event decode per mode
    always_comb begin
        // mode 1 two stages
        // second zero with the flag still standing forces the reset
        if (mode1) begin
            irq_evt = zero_evt && ctrl_r[`WDT_CTRL_INTEN];
            trig    = zero_evt && flag_r
                      && ctrl_r[`WDT_CTRL_RSTEN];
        end else begin
            irq_evt = zero_evt && ctrl_r[`WDT_CTRL_INTEN];
            trig    = zero_evt && ctrl_r[`WDT_CTRL_RSTEN];
        end
    end

    // the watchdog reset re-initialises the timer registers
    // while a pulse is already running no new one is started
    assign wd_clr = trig && pulse_r == 16'h0;

    // counter
    always_ff @(posedge clk_i) begin
        if (rst_i || wd_clr) begin
            count_r <= `WDT_RST_COUNT;
        end else if (key_ok) begin
            count_r <= reload_r;
        end else if (zero_evt) begin
            // mode 1 reloads and keeps going; mode 0 parks at zero
            count_r <= mode1 ? reload_r : 32'h0;
        end else if (ctrl_r[`WDT_CTRL_EN] && tick
                     && count_r != 32'h0) begin
            count_r <= count_r - 32'h1;
        end
        // hold when disabled
        // no branch taken: the counter keeps its value
    end

    // reload value register
    always_ff @(posedge clk_i) begin
        if (rst_i || wd_clr) begin
            reload_r <= `WDT_RST_RELOAD;
        end else if (wr && hit_reload) begin
            reload_r <= (reload_r & ~wmask) | (dat_i & wmask);
        end
    end

    // control register
    always_ff @(posedge clk_i) begin
        if (rst_i || wd_clr) begin
            ctrl_r <= `WDT_RST_CTRL;
        end else if (wr && hit_ctrl && sel_i[0]) begin
            // all five fields sit in the lowest byte
            // prescale code stored
            ctrl_r <= dat_i[`WDT_CTRL_W-1:0];
        end
    end

    // timeout status flag
    always_ff @(posedge clk_i) begin
        if (rst_i || wd_clr) begin
            flag_r <= 1'b0;
        // set at zero
        // a zero in the same cycle as a clear wins: no lost timeout
        end else if (zero_evt) begin
            flag_r <= 1'b1;
        end else if (wr && hit_fclr) begin
            flag_r <= 1'b0;
        end
    end

    // reset-cause register, not cleared by the watchdog reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cause_r <= `WDT_RST_CAUSE;
        end else begin
            if (wr && hit_cause && sel_i[0]) begin
                cause_r <= dat_i[1:0];
            end
            // mark watchdog reset
            // set wins over a software write in the same cycle
            if (wd_clr) begin
                cause_r[`WDT_CAUSE_WDOG] <= 1'b1;
            end
        end
    end

    // reset pulse length, kept across a watchdog reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            plen_r <= `WDT_RST_PLEN;
        end else if (wr && hit_plen) begin
            plen_r <= (plen_r & ~wmask[15:0])
                      | (dat_i[15:0] & wmask[15:0]);
        end
    end

    // reset pulse generator
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulse_r   <= 16'h0;
            wdt_rst_o <= 1'b0;
        // pulse width count
        // a length of zero still gives one cycle, so a reset is seen
        end else if (wd_clr) begin
            pulse_r   <= (plen_r == 16'h0) ? 16'h1 : plen_r;
            wdt_rst_o <= 1'b1;
        end else begin
            if (pulse_r != 16'h0) begin
                pulse_r <= pulse_r - 16'h1;
            end
            wdt_rst_o <= pulse_r > 16'h1;
        end
    end

    // sticky events: a read of the status register clears them,
    // but an event in the same cycle survives the read
    always_comb begin
        irq_st_nxt = irq_st_r;
        if (rd && hit_irqst) begin
            irq_st_nxt = 2'h0;
        end
        if (irq_evt) begin
            irq_st_nxt[`WDT_EVT_TIMEOUT] = 1'b1;
        end
        if (wd_clr) begin
            irq_st_nxt[`WDT_EVT_RESET] = 1'b1;
        end
    end

    // mask as it stands after this edge, so irq_o follows a mask
    // write in the same cycle as the mask register does
    always_comb begin
        irq_msk_nxt = irq_msk_r;
        if (wr && hit_irqmsk && sel_i[0]) begin
            irq_msk_nxt = dat_i[`WDT_EVT_W-1:0];
        end
    end

    // status and mask, both kept across a watchdog reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_st_r  <= 2'h0;
            irq_msk_r <= `WDT_RST_MASK;
        end else begin
            irq_st_r  <= irq_st_nxt;
            irq_msk_r <= irq_msk_nxt;
        end
    end

    // interrupt line from the next state, so it leaves a flip-flop
    // in step with the status register instead of a cycle behind
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_st_nxt & irq_msk_nxt);
        end
    end

    // bus acknowledge: one cycle after the request, then low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    // read data, captured with the acknowledge
    // write-only and unmapped words read as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0;
        end else if (rd) begin
            unique case (adr_i[7:2])
                IDX_COUNT:
                    dat_o <= count_r;
                IDX_RELOAD:
                    dat_o <= reload_r;
                IDX_CTRL:
                    dat_o <= {26'h0, ctrl_r};
                IDX_FLAG:
                    dat_o <= {31'h0, flag_r};
                IDX_CAUSE:
                    dat_o <= {30'h0, cause_r};
                IDX_PLEN:
                    dat_o <= {16'h0, plen_r};
                // status shows its value before this read clears it
                IDX_IRQST:
                    dat_o <= {30'h0, irq_st_r};
                IDX_IRQMSK:
                    dat_o <= {30'h0, irq_msk_r};
                default:
                    dat_o <= 32'h0;
            endcase
        end else begin
            // idle bus shows zero rather than stale data
            dat_o <= 32'h0;
        end
    end
endmodule

//--- rtl/wdt_consts.svh
// constants of the watchdog timer unit: offsets, field positions,
// reset values; included by the package and the top-level design file
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// register byte offsets inside the unit
`define WDT_OFF_COUNT   8'h94
`define WDT_OFF_RELOAD  8'h98
`define WDT_OFF_RESTART 8'h9C
`define WDT_OFF_CTRL    8'hA0
`define WDT_OFF_FLAG    8'hA4
`define WDT_OFF_FCLR    8'hA8
`define WDT_OFF_CAUSE   8'hAC
`define WDT_OFF_PLEN    8'hB0
`define WDT_OFF_IRQST   8'hB4
`define WDT_OFF_IRQMSK  8'hB8

// control register fields
`define WDT_CTRL_EN     0
`define WDT_CTRL_RSTEN  1
`define WDT_CTRL_INTEN  2
`define WDT_CTRL_MODE   3
`define WDT_CTRL_PS_LO  4
`define WDT_CTRL_PS_HI  5
`define WDT_CTRL_W      6

// reset-cause fields
`define WDT_CAUSE_WDOG  0
`define WDT_CAUSE_SOFT  1

// sticky event bits of the interrupt status register
`define WDT_EVT_TIMEOUT 0
`define WDT_EVT_RESET   1
`define WDT_EVT_W       2

// reset values
`define WDT_RST_COUNT   32'h05B8D800
`define WDT_RST_RELOAD  32'h05B8D800
`define WDT_RST_CTRL    6'h00
`define WDT_RST_CAUSE   2'h0
`define WDT_RST_PLEN    16'h00FF
`define WDT_RST_MASK    2'h0

`endif

//--- rtl/wdt_pkg.sv
// types shared by the watchdog timer unit files
// assumes the constants header sits beside it under rtl/
`include "wdt_consts.svh"

package wdt_pkg;
    // prescale codes of the control register
    typedef enum logic [1:0] {
        WDT_DIV1 = 2'h0,
        WDT_DIV2 = 2'h1,
        WDT_DIV4 = 2'h2,
        WDT_DIV8 = 2'h3
    } wdt_div_t;

    // one bus word
    typedef logic [31:0] wdt_word_t;
endpackage

//--- rtl/wdt_prescaler.sv
// tick generator that divides the counter clock by 1, 2, 4 or 8
// assumes one clock, synchronous active-high reset
module wdt_prescaler (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             en_i,
    input  wire logic             clr_i,
    input  wire wdt_pkg::wdt_div_t div_i,
    output logic                  tick_o
);
    logic [2:0] cnt_r;   // cycles since the last tick
    logic [2:0] lim;     // last count before a tick

    // terminal count per prescale code
    always_comb begin
        unique case (div_i)
            wdt_pkg::WDT_DIV1: lim = 3'h0;
            wdt_pkg::WDT_DIV2: lim = 3'h1;
            wdt_pkg::WDT_DIV4: lim = 3'h3;
            wdt_pkg::WDT_DIV8: lim = 3'h7;
        endcase
    end

    // free count, restarted by a reload so a period starts clean
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i || !en_i) begin
            cnt_r  <= 3'h0;
            tick_o <= 1'b0;
        end else if (cnt_r >= lim) begin
            cnt_r  <= 3'h0;
            tick_o <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 3'h1;
            tick_o <= 1'b0;
        end
    end
endmodule

//--- bench/wdt_chk.sv
// port checker for the watchdog unit
// assumes one clock and a synchronous active-high reset
module wdt_chk (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    input  wire logic [31:0] dat_o,
    input  wire logic        ack_o,
    input  wire logic        wdt_rst_o,
    input  wire logic        irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic        req;   // request taken at this edge
    logic [15:0] len_r; // shadow of the pulse length
    logic [16:0] run_r; // edges the pulse has stood
    assign req = cyc_i && stb_i && !ack_o;
    // shadow follows byte-lane writes, power-on default only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            len_r <= 16'h00FF;
        end else if (req && we_i && adr_i[7:2] == 6'h2C) begin
            if (sel_i[0]) len_r[7:0] <= dat_i[7:0];
            if (sel_i[1]) len_r[15:8] <= dat_i[15:8];
        end
    end
    // length of the running pulse
    always_ff @(posedge clk_i) begin
        if (rst_i || !wdt_rst_o) run_r <= 17'h0;
        else run_r <= run_r + 17'h1;
    end
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    property p_ack_next; req |=> ack_o; endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("request not answered next cycle");
    property p_ack_cause; ack_o |-> $past(req); endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without request");
    property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle)
        else $error("read data outside ack");
    // reset quiets ack_o, wdt_rst_o and irq_o whatever else happens
    property p_por;
        disable iff (1'b0) rst_i |=> !ack_o && !wdt_rst_o && !irq_o;
    endproperty
    a_por: assert property (p_por)
        else $error("outputs active after reset");
    property p_pulse_len;
        $fell(wdt_rst_o) |->
            run_r == ((len_r == 16'h0) ? 17'h1 : {1'b0, len_r});
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("reset pulse length wrong");
    property p_flag_width;
        ack_o && $past(!we_i && adr_i[7:2] == 6'h29) |->
            dat_o[31:1] == 31'h0;
    endproperty
    a_flag_width: assert property (p_flag_width)
        else $error("flag read wider than one bit");
    // irq only drops on a status read or a mask write
    property p_irq_fall;
        $fell(irq_o) |-> $past(req && (adr_i[7:2] == 6'h2D ||
            adr_i[7:2] == 6'h2E));
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("irq dropped without cause");
    c_irq: cover property ($rose(irq_o));
    c_pulse: cover property ($fell(wdt_rst_o));
    c_key: cover property (req && we_i && adr_i[7:2] == 6'h27);
endmodule
bind wdt_top wdt_chk wdt_chk_i (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .wdt_rst_o(wdt_rst_o), .irq_o(irq_o));

//--- bench/watchdog_timer_unit_bench.sv
// self-checking bench for the watchdog unit
// assumes the rtl files and the checker are compiled first
module watchdog_timer_unit_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] KEY = 32'h5A5AC3C3; // arbitrary key
    localparam logic [31:0] DEF = 32'h05B8D800; // counter default
    logic               clk_i, rst_i, cyc_i, stb_i, we_i;
    logic               ack_o, wdt_rst_o, irq_o;
    logic [7:0]         adr_i;
    logic [3:0]         sel_i;
    wdt_pkg::wdt_word_t dat_i, dat_o, d, e, a_v;
    int                 bad_count, n_compared, seed, t, c, n, ta, tb;
    int                 cyc_n = 0;
    wdt_top #(.RESTART_KEY(KEY)) wdt_top_i (.clk_i(clk_i),
        .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .wdt_rst_o(wdt_rst_o), .irq_o(irq_o));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // hang guard, well above the planned run
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            bad_count++;
            results;
        end
    end
    task automatic chk(string nm, wdt_pkg::wdt_word_t ex,
                       wdt_pkg::wdt_word_t got);
        n_compared++;
        if (got !== ex) begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", nm, ex, got);
        end
    endtask
    // expected reset pulse width: a zero length still gives one cycle
    function automatic wdt_pkg::wdt_word_t exp_pulse(logic [15:0] len);
        return (len == 16'h0) ? 32'h1 : {16'h0, len};
    endfunction
    // one classic cycle; held until ack is sampled high
    task automatic bus(logic w, logic [7:0] a, wdt_pkg::wdt_word_t wd);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= wd;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        d = dat_o;
        tb = cyc_n;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask
    task automatic wr(logic [7:0] a, wdt_pkg::wdt_word_t v);
        bus(1'b1, a, v);
    endtask
    task automatic rc(logic [7:0] a, wdt_pkg::wdt_word_t ex, string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, ex, d);
    endtask
    // bounded wait on the reset (1) or interrupt (0) output
    task automatic wait_hi(logic which);
        t = 0;
        while ((which ? wdt_rst_o : irq_o) !== 1'b1 && t < 600) begin
            @(posedge clk_i);
            t++;
        end
        chk("wait", 32'h0, {31'h0, t >= 600});
    endtask
    initial begin
        seed = 12;
        {cyc_i, stb_i, we_i, rst_i} = 4'h1;
        adr_i = 8'h00;
        sel_i = 4'hF;
        dat_i = 32'h0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        // table reset values, unmapped and write-only reads
        rc(8'h94, DEF, "count");
        rc(8'h98, DEF, "reload");
        rc(8'hA0, 32'h0, "ctrl");
        rc(8'hA4, 32'h0, "flag");
        rc(8'hAC, 32'h0, "cause");
        rc(8'hB0, 32'h00FF, "length");
        rc(8'h9C, 32'h0, "key read");
        rc(8'hC0, 32'h0, "unmapped");
        wr(8'h94, 32'h1234);
        rc(8'h94, DEF, "count ro");
        for (c = 0; c < 4; c++) begin
            e = $random(seed);
            wr(8'h98, e);
            rc(8'h98, e, "reload rw");
        end
        wr(8'h98, 32'h5);
        e = $random(seed);
        if (e == KEY) e = ~e;
        wr(8'h9C, e);
        rc(8'h94, DEF, "bad key");
        wr(8'h9C, KEY);
        rc(8'h94, 32'h5, "restart");
        repeat (9) @(posedge clk_i);
        rc(8'h94, 32'h5, "held");
        // every prescale code; rate judged within one tick
        for (c = 0; c < 4; c++) begin
            wr(8'h98, 32'h1000);
            wr(8'h9C, KEY);
            wr(8'hA0, (c << 4) | 1);
            rc(8'hA0, (c << 4) | 1, "ctrl rw");
            ta = tb;
            a_v = d;
            bus(1'b0, 8'h94, 32'h0);
            a_v = d;
            ta = tb;
            repeat (40) @(posedge clk_i);
            bus(1'b0, 8'h94, 32'h0);
            e = (a_v - d) << c;
            n = tb - ta;
            chk("rate", 32'h1, {31'h0, e + (1 << c) >= n &&
                e <= n + (1 << c)});
            wr(8'hA0, 32'h0);
        end
        // mode 0, interrupt only, first masked
        wr(8'hB8, 32'h0);
        wr(8'h98, 32'h3);
        wr(8'h9C, KEY);
        wr(8'hA0, 32'h5);
        t = 0;
        d = 32'h0;
        while (d !== 32'h1 && t < 50) begin
            bus(1'b0, 8'hA4, 32'h0);
            t++;
        end
        chk("flag set", 32'h1, d);
        chk("irq masked", 32'h0, {31'h0, irq_o});
        chk("no reset", 32'h0, {31'h0, wdt_rst_o});
        rc(8'h94, 32'h0, "parked");
        wr(8'hB8, 32'h1);
        repeat (3) @(posedge clk_i);
        chk("irq on", 32'h1, {31'h0, irq_o});
        rc(8'hB4, 32'h1, "status");
        repeat (3) @(posedge clk_i);
        chk("irq off", 32'h0, {31'h0, irq_o});
        wr(8'hA8, $random(seed));
        rc(8'hA4, 32'h0, "flag clear");
        // mode 0 with reset: pulse, cause record, defaults
        wr(8'hAC, 32'h2);
        rc(8'hAC, 32'h2, "soft flag");
        wr(8'hB0, 32'h3);
        wr(8'hB8, 32'h3);
        wr(8'h98, 32'h5);
        wr(8'h9C, KEY);
        wr(8'hA0, 32'h7);
        wait_hi(1'b1);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wdt_rst_o === 1'b1 && n < 300);
        chk("pulse", exp_pulse(16'h3), n);
        chk("irq both", 32'h1, {31'h0, irq_o});
        rc(8'hAC, 32'h3, "cause wd");
        rc(8'hA0, 32'h0, "ctrl wd");
        rc(8'h94, DEF, "count wd");
        rc(8'h98, DEF, "reload wd");
        rc(8'hB0, 32'h3, "length kept");
        rc(8'hB4, 32'h3, "status both");
        wr(8'hAC, 32'h0);
        rc(8'hAC, 32'h0, "cause clear");
        // mode 1: interrupt first, reset on a zero that finds the flag set
        wr(8'h98, 32'h14);
        wr(8'h9C, KEY);
        wr(8'hA0, 32'hF);
        wait_hi(1'b0);
        chk("no early reset", 32'h0, {31'h0, wdt_rst_o});
        rc(8'hA4, 32'h1, "flag m1");
        // a cleared flag lets the second zero pass with no reset
        wr(8'hA8, 32'h0);
        rc(8'hB4, 32'h1, "status m1");
        wait_hi(1'b0);
        chk("cleared no reset", 32'h0, {31'h0, wdt_rst_o});
        wait_hi(1'b1);
        repeat (8) @(posedge clk_i);
        rc(8'hAC, 32'h1, "cause m1");
        // second power-on resets to their defaults what a watchdog reset keeps
        rst_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(8'hAC, 32'h0, "cause por");
        rc(8'hB0, 32'h00FF, "length por");
        results;
    end
endmodule
